// File: pcr_pkg.sv
package pcr_pkg;

    // two banks: index 0 system synthesizer, index 1 usb synthesizer
    localparam int PCR_NUM_BANKS = 2;
    localparam logic [1:0][31:0] PCR_BASE = {32'h4002_c000, 32'h4002_8000};

    // word offsets inside a bank
    localparam logic [3:0] PCR_OFF_CTRL = 4'h0;
    localparam logic [3:0] PCR_OFF_PWR = 4'h4;
    localparam logic [3:0] PCR_OFF_FBDIV = 4'h8;
    localparam logic [3:0] PCR_OFF_POST = 4'hc;

    // field positions
    localparam int PCR_LOCK_BIT = 31;
    localparam int PCR_BYPASS_BIT = 8;
    localparam int PCR_REFDIV_LSB = 0;
    localparam int PCR_OSC_PD_BIT = 5;
    localparam int PCR_POST_PD_BIT = 3;
    localparam int PCR_SDM_PD_BIT = 2;
    localparam int PCR_MAIN_PD_BIT = 0;
    localparam int PCR_FBDIV_LSB = 0;
    localparam int PCR_PD1_LSB = 16;
    localparam int PCR_PD2_LSB = 12;

    // values after reset
    localparam logic [5:0] PCR_RST_REFDIV = 6'h01;
    localparam logic PCR_RST_BYPASS = 1'h0;
    localparam logic PCR_RST_PWR = 1'h1;
    localparam logic [11:0] PCR_RST_FBDIV = 12'h000;
    localparam logic [2:0] PCR_RST_POSTDIV = 3'h7;

    // settling time of the loop model
    localparam int PCR_CLK_PERIOD_NS = 100;
    localparam int PCR_LOCK_TIME_NS = 1000;
    localparam int PCR_LOCK_CYCLES =
        (PCR_LOCK_TIME_NS + PCR_CLK_PERIOD_NS - 1) / PCR_CLK_PERIOD_NS;
    localparam logic [7:0] PCR_LOCK_LAST = 8'(PCR_LOCK_CYCLES - 1);

    typedef enum logic [2:0] {
        PCR_LK_OFF = 3'h1,
        PCR_LK_SETTLE = 3'h2,
        PCR_LK_LOCKED = 3'h4
    } pcr_lock_st_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pcr_bus_t;

    typedef struct packed {
        logic [5:0] refdiv;
        logic bypass;
        logic osc_pd;
        logic post_pd;
        logic sdm_pd;
        logic main_pd;
        logic [11:0] fbdiv;
        logic [2:0] pd1;
        logic [2:0] pd2;
        pcr_lock_st_t lock_st;
        logic [7:0] lock_cnt;
        logic [5:0] ref_cnt;
        logic cmp_ref;
        logic [5:0] post_cnt;
        logic osc_div;
        logic synth;
    } pcr_bank_t;

endpackage

// File: pcr_synth_regs.sv
// Chosen here: the plain strobed port.
module pcr_synth_regs (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire pcr_pkg::pcr_bus_t i_bus,
    input wire logic i_ref_clk,
    output logic [31:0] o_rdata,
    output logic [pcr_pkg::PCR_NUM_BANKS-1:0] o_synth_clk,
    output logic [pcr_pkg::PCR_NUM_BANKS-1:0] o_cmp_ref,
    output logic [pcr_pkg::PCR_NUM_BANKS-1:0] o_lock
);
    import pcr_pkg::*;

    typedef struct packed {
        logic ref_s1;
        logic ref_s2;
        logic ref_prev;
        logic [31:0] rdata;
        pcr_bank_t [PCR_NUM_BANKS-1:0] bank;
    } pcr_state_t;

    pcr_state_t st_r;
    pcr_state_t st_nxt;
    logic [PCR_NUM_BANKS-1:0][31:0] rd_word;

    // address hit on one bank; misaligned addresses never hit
    function automatic logic bank_hit(input logic [31:0] a, input logic [31:0] base);
        return (a[31:4] == base[31:4]) && (a[1:0] == 2'h0);
    endfunction

    // read view of one bank; reserved bits read zero
    function automatic logic [31:0] reg_word(input pcr_bank_t b, input logic [3:0] off);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (off)
            PCR_OFF_CTRL: begin
                w[PCR_LOCK_BIT] = (b.lock_st == PCR_LK_LOCKED);
                w[PCR_BYPASS_BIT] = b.bypass;
                w[PCR_REFDIV_LSB +: 6] = b.refdiv;
            end
            PCR_OFF_PWR: begin
                w[PCR_OSC_PD_BIT] = b.osc_pd;
                w[PCR_POST_PD_BIT] = b.post_pd;
                w[PCR_SDM_PD_BIT] = b.sdm_pd;
                w[PCR_MAIN_PD_BIT] = b.main_pd;
            end
            PCR_OFF_FBDIV: begin
                w[PCR_FBDIV_LSB +: 12] = b.fbdiv;
            end
            PCR_OFF_POST: begin
                w[PCR_PD1_LSB +: 3] = b.pd1;
                w[PCR_PD2_LSB +: 3] = b.pd2;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    // one read view per bank
    generate
        for (genvar g = 0; g < PCR_NUM_BANKS; g++) begin : g_bank
            assign rd_word[g] = reg_word(st_r.bank[g], i_bus.addr[3:0]);
            assign o_synth_clk[g] = st_r.bank[g].synth;
            assign o_cmp_ref[g] = st_r.bank[g].cmp_ref;
            assign o_lock[g] = (st_r.bank[g].lock_st == PCR_LK_LOCKED);
        end
    endgenerate

    assign o_rdata = st_r.rdata;

    // next state of the whole block
    always_comb begin
        logic ref_rise;
        logic reprog;
        logic powered;
        logic osc_run;
        logic [5:0] post_div;
        logic [5:0] ref_last;
        pcr_bank_t nb;
        ref_rise = 1'b0;
        reprog = 1'b0;
        powered = 1'b0;
        osc_run = 1'b0;
        post_div = 6'h00;
        ref_last = 6'h00;
        nb = st_r.bank[0];
        st_nxt = st_r;

        // reference pin passes two flops before anything looks at it
        st_nxt.ref_s1 = i_ref_clk;
        st_nxt.ref_s2 = st_r.ref_s1;
        st_nxt.ref_prev = st_r.ref_s2;
        ref_rise = st_r.ref_s2 & ~st_r.ref_prev;

        // read data stands for one cycle only; unmapped reads give zero
        st_nxt.rdata = 32'h0000_0000;
        if (i_bus.rd) begin
            for (int b = 0; b < PCR_NUM_BANKS; b++) begin
                if (bank_hit(i_bus.addr, PCR_BASE[b])) begin
                    st_nxt.rdata = rd_word[b];
                end
            end
        end

        for (int b = 0; b < PCR_NUM_BANKS; b++) begin
            nb = st_r.bank[b];
            reprog = 1'b0;

            // register writes; lock bit is not writable
            if (i_bus.wr && bank_hit(i_bus.addr, PCR_BASE[b])) begin
                case (i_bus.addr[3:0])
                    PCR_OFF_CTRL: begin
                        nb.refdiv = i_bus.wdata[PCR_REFDIV_LSB +: 6];
                        nb.bypass = i_bus.wdata[PCR_BYPASS_BIT];
                        reprog = 1'b1;
                    end
                    PCR_OFF_PWR: begin
                        nb.osc_pd = i_bus.wdata[PCR_OSC_PD_BIT];
                        nb.post_pd = i_bus.wdata[PCR_POST_PD_BIT];
                        nb.sdm_pd = i_bus.wdata[PCR_SDM_PD_BIT];
                        nb.main_pd = i_bus.wdata[PCR_MAIN_PD_BIT];
                    end
                    PCR_OFF_FBDIV: begin
                        // integer only, no fractional part exists
                        nb.fbdiv = i_bus.wdata[PCR_FBDIV_LSB +: 12];
                        reprog = 1'b1;
                    end
                    PCR_OFF_POST: begin
                        nb.pd1 = i_bus.wdata[PCR_PD1_LSB +: 3];
                        nb.pd2 = i_bus.wdata[PCR_PD2_LSB +: 3];
                    end
                    default: begin
                        reprog = 1'b0;
                    end
                endcase
            end

            // loop model: settles only with main and oscillator powered
            powered = ~nb.main_pd & ~nb.osc_pd;
            case (st_r.bank[b].lock_st)
                PCR_LK_OFF: begin
                    nb.lock_cnt = 8'h00;
                    if (powered) begin
                        nb.lock_st = PCR_LK_SETTLE;
                    end
                end
                PCR_LK_SETTLE: begin
                    if (!powered) begin
                        nb.lock_st = PCR_LK_OFF;
                        nb.lock_cnt = 8'h00;
                    end else if (reprog) begin
                        nb.lock_cnt = 8'h00;
                    end else if (st_r.bank[b].lock_cnt == PCR_LOCK_LAST) begin
                        nb.lock_st = PCR_LK_LOCKED;
                        nb.lock_cnt = 8'h00;
                    end else begin
                        nb.lock_cnt = st_r.bank[b].lock_cnt + 8'h01;
                    end
                end
                PCR_LK_LOCKED: begin
                    nb.lock_cnt = 8'h00;
                    if (!powered) begin
                        nb.lock_st = PCR_LK_OFF;
                    end else if (reprog) begin
                        // divider change makes the output unusable until relock
                        nb.lock_st = PCR_LK_SETTLE;
                    end
                end
                default: begin
                    nb.lock_st = PCR_LK_OFF;
                    nb.lock_cnt = 8'h00;
                end
            endcase

            // reference divider, counts synchronised rising edges;
            // a zero divider behaves as one, its value is undefined anyway
            ref_last = (nb.refdiv == 6'h00) ? 6'h00 : nb.refdiv - 6'h01;
            if (nb.main_pd) begin
                nb.ref_cnt = 6'h00;
                nb.cmp_ref = 1'b0;
            end else if (ref_rise) begin
                if (st_r.bank[b].ref_cnt >= ref_last) begin
                    nb.ref_cnt = 6'h00;
                    nb.cmp_ref = ~st_r.bank[b].cmp_ref;
                end else begin
                    nb.ref_cnt = st_r.bank[b].ref_cnt + 6'h01;
                end
            end

            // oscillator modelled as one tick per clock, then post dividers;
            // it runs whatever bypass says so switching back is instant
            osc_run = ~nb.main_pd & ~nb.osc_pd & ~nb.post_pd;
            post_div = {3'h0, nb.pd1} * {3'h0, nb.pd2};
            if (!osc_run) begin
                nb.post_cnt = 6'h00;
                nb.osc_div = 1'b0;
            end else if (st_r.bank[b].post_cnt >= post_div - 6'h01) begin
                nb.post_cnt = 6'h00;
                nb.osc_div = ~st_r.bank[b].osc_div;
            end else begin
                nb.post_cnt = st_r.bank[b].post_cnt + 6'h01;
            end

            // single primary output; the mux may glitch on a bypass change
            if (nb.bypass) begin
                nb.synth = st_r.ref_s2;
            end else begin
                nb.synth = nb.osc_div & osc_run;
            end

            st_nxt.bank[b] = nb;
        end
    end

    // one register for all state; clock enable freezes everything except the reset, which loads even with i_ce low
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r.ref_s1 <= 1'b0;
            st_r.ref_s2 <= 1'b0;
            st_r.ref_prev <= 1'b0;
            st_r.rdata <= 32'h0000_0000;
            for (int b = 0; b < PCR_NUM_BANKS; b++) begin
                st_r.bank[b].refdiv <= PCR_RST_REFDIV;
                st_r.bank[b].bypass <= PCR_RST_BYPASS;
                st_r.bank[b].osc_pd <= PCR_RST_PWR;
                st_r.bank[b].post_pd <= PCR_RST_PWR;
                st_r.bank[b].sdm_pd <= PCR_RST_PWR;
                st_r.bank[b].main_pd <= PCR_RST_PWR;
                st_r.bank[b].fbdiv <= PCR_RST_FBDIV;
                st_r.bank[b].pd1 <= PCR_RST_POSTDIV;
                st_r.bank[b].pd2 <= PCR_RST_POSTDIV;
                st_r.bank[b].lock_st <= PCR_LK_OFF;
                st_r.bank[b].lock_cnt <= 8'h00;
                st_r.bank[b].ref_cnt <= 6'h00;
                st_r.bank[b].cmp_ref <= 1'b0;
                st_r.bank[b].post_cnt <= 6'h00;
                st_r.bank[b].osc_div <= 1'b0;
                st_r.bank[b].synth <= 1'b0;
            end
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

endmodule

// File: pcr_synth_regs_asserts.sv
module pcr_synth_regs_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire pcr_pkg::pcr_bus_t i_bus,
    input wire logic i_ref_clk,
    input wire logic [31:0] o_rdata,
    input wire logic [pcr_pkg::PCR_NUM_BANKS-1:0] o_synth_clk,
    input wire logic [pcr_pkg::PCR_NUM_BANKS-1:0] o_cmp_ref,
    input wire logic [pcr_pkg::PCR_NUM_BANKS-1:0] o_lock
);
    import pcr_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic hit;
    logic rd0;
    logic [3:0] off;
    // bank 0 decode; misaligned addresses never count as a hit
    assign hit = i_ce && i_bus.addr[31:4] == PCR_BASE[0][31:4] && i_bus.addr[1:0] == 2'h0;
    assign rd0 = hit && i_bus.rd;
    assign off = i_bus.addr[3:0];
    AST_IDLE_ZERO: assert property (i_ce && !i_bus.rd |=> o_rdata == 32'h0)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (i_ce && i_bus.rd && i_bus.addr[15:4] == 12'h801 |=> o_rdata == 32'h0)
        else $error("unmapped read returned data");
    AST_CTRL_BITS: assert property (rd0 && off == PCR_OFF_CTRL |=> o_rdata[30:9] == 22'h0 && o_rdata[7:6] == 2'h0 && o_rdata[31] == $past(o_lock[0]))
        else $error("control word reserved bits or lock mismatch");
    AST_PWR_BITS: assert property (rd0 && off == PCR_OFF_PWR |=> o_rdata[31:6] == 26'h0 && !o_rdata[4] && !o_rdata[1])
        else $error("power word reserved bits set");
    AST_FB_BITS: assert property (rd0 && off == PCR_OFF_FBDIV |=> o_rdata[31:12] == 20'h0)
        else $error("divisor word reserved bits set");
    AST_POST_BITS: assert property (rd0 && off == PCR_OFF_POST |=> o_rdata[31:19] == 13'h0 && !o_rdata[15] && o_rdata[11:0] == 12'h0)
        else $error("post divider word reserved bits set");
    AST_LOCK_DROP: assert property (hit && i_bus.wr && (off == PCR_OFF_CTRL || off == PCR_OFF_FBDIV) |=> !o_lock[0])
        else $error("lock held across divider write");
    AST_LOCK_PD: assert property (hit && i_bus.wr && off == PCR_OFF_PWR && (i_bus.wdata[0] || i_bus.wdata[5]) |-> ##2 !o_lock[0])
        else $error("lock held while powered down");
    // settling may not be cut short; a restart write inside it would also show here
    AST_LOCK_SETTLE: assert property (hit && i_bus.wr && off == PCR_OFF_PWR && !i_bus.wdata[0] && !i_bus.wdata[5] && !o_lock[0] |=> !o_lock[0] [*8] ##[1:6] o_lock[0])
        else $error("lock timing off");
    cover property (hit && i_bus.wr && off == PCR_OFF_PWR);
    cover property ($rose(o_lock[0]));
    cover property (rd0 && off == PCR_OFF_CTRL ##1 o_rdata[31]);
endmodule
bind pcr_synth_regs pcr_synth_regs_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_bus(i_bus), .i_ref_clk(i_ref_clk), .o_rdata(o_rdata), .o_synth_clk(o_synth_clk),
    .o_cmp_ref(o_cmp_ref), .o_lock(o_lock));

// File: tb_pcr_synth_regs.sv
module tb_pcr_synth_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import pcr_pkg::*;
    logic i_clk;
    logic i_rst;
    logic i_ce;
    pcr_bus_t i_bus;
    logic i_ref_clk;
    logic [31:0] o_rdata;
    logic [1:0] o_synth_clk;
    logic [1:0] o_cmp_ref;
    logic [1:0] o_lock;
    int fail_count;
    int num_checks;
    logic [31:0] v;
    localparam logic [31:0] B0 = PCR_BASE[0];
    pcr_synth_regs uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_bus(i_bus),
        .i_ref_clk(i_ref_clk), .o_rdata(o_rdata), .o_synth_clk(o_synth_clk),
        .o_cmp_ref(o_cmp_ref), .o_lock(o_lock));
    // 100 ns bus clock
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // strobe then one idle cycle, so no signal is driven twice in a step
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus.wr <= 1'b0;
        @(posedge i_clk);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        i_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus.rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_clk);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        rd(a, v);
        check(v, exp);
    endtask
    // poll status through the bus, lock may take tens of cycles at most
    task automatic poll_lock();
        v = '0;
        for (int n = 0; n < 30 && v[31] !== 1'b1; n++) begin
            rd(B0, v);
        end
        check({31'h0, v[31]}, 32'h1);
    endtask
    // cycles between two rising edges of the bank 0 output
    task automatic period(output int p);
        int t0;
        logic prev;
        t0 = -1;
        p = 0;
        prev = o_synth_clk[0];
        for (int n = 0; n < 80 && p == 0; n++) begin
            @(posedge i_clk);
            #1;
            if (o_synth_clk[0] === 1'b1 && prev === 1'b0) begin
                if (t0 < 0) t0 = n;
                else p = n - t0;
            end
            prev = o_synth_clk[0];
        end
    endtask
    task automatic t_reset_map();
        for (int b = 0; b < 2; b++) begin
            rd_chk(PCR_BASE[b], 32'h0000_0001);
            rd_chk(PCR_BASE[b] + 32'h4, 32'h0000_002d);
            rd_chk(PCR_BASE[b] + 32'h8, 32'h0);
            rd_chk(PCR_BASE[b] + 32'hc, 32'h0007_7000);
        end
        check({28'h0, o_lock, o_synth_clk}, 32'h0);
    endtask
    task automatic t_masks();
        wr(B0, 32'hffff_ffff);
        rd_chk(B0, 32'h0000_013f);
        wr(B0 + 32'h4, 32'h0000_0021);
        rd_chk(B0 + 32'h4, 32'h0000_0021);
        wr(B0 + 32'h8, 32'hffff_ffff);
        rd_chk(B0 + 32'h8, 32'h0000_0fff);
        wr(B0 + 32'hc, 32'hffff_ffff);
        rd_chk(B0 + 32'hc, 32'h0007_7000);
        rd_chk(PCR_BASE[1], 32'h0000_0001);
        rd_chk(B0 + 32'h10, 32'h0);
        rd_chk(B0 + 32'h1, 32'h0);
        // 12MHz ref /1 * 100 keeps comparator and oscillator in range
        wr(B0, 32'h1);
        wr(B0 + 32'h8, 32'h64);
        wr(B0 + 32'hc, 32'h0002_3000);
    endtask
    task automatic t_lock_and_output();
        int p;
        int tg;
        logic pv;
        // dividers already loaded, now power, lock, then post dividers
        wr(B0 + 32'h4, 32'h0000_000c);
        rd_chk(B0, 32'h0000_0001);
        poll_lock();
        wr(B0 + 32'h8, 32'h64);
        check({31'h0, o_lock[0]}, 32'h0);
        poll_lock();
        wr(B0 + 32'h4, 32'h0000_0004);
        period(p);
        check(32'(p), 32'd12);
        wr(B0, 32'h101);
        for (int k = 0; k < 4; k++) begin
            i_ref_clk <= k[0] ? 1'b0 : 1'b1;
            repeat (4) @(posedge i_clk);
            check({31'h0, o_synth_clk[0]}, {31'h0, ~k[0]});
        end
        wr(B0, 32'h2);
        period(p);
        check(32'(p), 32'd12);
        // eight reference rises over a divide by two give four toggles
        tg = 0;
        #1 pv = o_cmp_ref[0];
        for (int k = 0; k < 16; k++) begin
            i_ref_clk <= ~i_ref_clk;
            repeat (3) @(posedge i_clk);
            #1;
            if (o_cmp_ref[0] !== pv) tg++;
            pv = o_cmp_ref[0];
        end
        check(32'(tg), 32'h4);
        check({31'h0, o_synth_clk[1]}, 32'h0);
        wr(B0 + 32'h4, 32'h0000_002d);
        check({31'h0, o_lock[0]}, 32'h0);
    endtask
    // reset, then the scenarios in order
    initial begin
        fail_count = 0;
        num_checks = 0;
        v = '0;
        i_rst = 1'b1;
        i_ce = 1'b1;
        i_ref_clk = 1'b0;
        i_bus = '0;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_reset_map();
        t_masks();
        t_lock_and_output();
        tally_and_finish();
    end
endmodule
